//--- core/adc_ctl_pkg.sv
package adc_ctl_pkg;
  // Range pin code that selects software mode
  localparam logic [1:0] RANGE_SW_CODE = 2'h0;
  // Filter corner settings
  localparam logic [1:0] FILT_SET_ONE = 2'h0;
  localparam logic [1:0] FILT_SET_TWO = 2'h1;
  localparam logic [1:0] FILT_SET_THREE = 2'h2;
  // Multiplexer input index of the internal diagnostic path
  localparam logic [3:0] MUX_DIAG_IDX = 4'h8;
  // Oversampling code that disables averaging
  localparam logic [2:0] OSR_OFF = 3'h0;
  // Cycles after reset release before the strap pins are sampled
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 23;
  localparam int MEM_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_WAIT,
    ST_FINISH
  } ctl_state_t;

  function automatic logic [6:0] osr_last_f(input logic [2:0] code);
    logic [7:0] ratio;
    ratio = 8'h1 << code;
    return 7'(ratio - 8'h1);
  endfunction
endpackage

//--- core/prev_mean_mem.sv
`timescale 1ns/1ps
module prev_mean_mem
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write side
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [SAMPLE_W-1:0] wr_data,
  // Read side
  input wire logic [3:0] rd_addr,
  output logic [SAMPLE_W-1:0] rd_data,
  output logic rd_valid
);
  logic [SAMPLE_W-1:0] mem [MEM_DEPTH];
  logic [MEM_DEPTH-1:0] valid_reg;

  // Array has no reset; the valid bits hide stale words
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      valid_reg <= '0;
      rd_valid <= 1'b0;
    end else begin
      if (wr_en) begin
        valid_reg[wr_addr] <= 1'b1;
      end
      rd_valid <= valid_reg[rd_addr];
    end
  end
endmodule

//--- core/adc_mux_oversample_control.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: Software filter setting picks corner option
// RULE2: Nine-way mux per group, ninth is diagnostics
// RULE3: Hardware pair taken from pins at reset
// RULE4: Hardware pins resampled during each conversion
// RULE5: Diagnostics unreachable in hardware mode
// RULE6: Software mode uses configured channel selection
// RULE7: Sequencer and burst in both modes
// RULE8: Ratio from pins or software bits
// RULE9: One ratio; code maps to power two
// RULE10: First sample on edge, rest internal
// RULE11: Average and decimate to 16-bit result
// RULE12: Finish channel samples before sequencer advances
// RULE13: Result rate drops with ratio
// RULE14: Second-order sinc, bypassed when off
// RULE15: Both range pins low selects software
// RULE16: Hardware pairs matching index; software any
// RULE17: Sequencer pin latched leaving reset
module adc_mux_oversample_control
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Device pins
  input wire logic [1:0] range_select_pins,
  input wire logic sequencer_enable_pin,
  input wire logic [2:0] channel_pair_select_pins,
  input wire logic [2:0] oversample_ratio_pins,
  input wire logic conversion_start_pin,
  // Software configuration
  input wire logic [3:0] sw_chan_a_sel,
  input wire logic [3:0] sw_chan_b_sel,
  input wire logic sw_diag_sel,
  input wire logic [2:0] oversample_ratio_bits,
  input wire logic [1:0] sw_filter_setting,
  input wire logic sw_seq_enable,
  input wire logic burst_enable,
  input wire logic [2:0] seq_last_index,
  // Converter core
  output logic sample_strobe,
  input wire logic adc_done,
  input wire logic [SAMPLE_W-1:0] adc_data_a,
  input wire logic [SAMPLE_W-1:0] adc_data_b,
  // Analog front end control
  output logic [3:0] mux_a_sel,
  output logic [3:0] mux_b_sel,
  output logic diag_sel,
  output logic [1:0] filter_corner_sel,
  // Status and results
  output logic software_mode,
  output logic busy,
  output logic result_valid,
  output logic [SAMPLE_W-1:0] result_a,
  output logic [SAMPLE_W-1:0] result_b,
  output logic [3:0] result_chan_a,
  output logic [3:0] result_chan_b
);
  logic [1:0] rng_s1_reg, rng_sync;
  logic seq_s1_reg, seq_sync;
  logic [2:0] chsel_s1_reg, chsel_sync;
  logic [2:0] osp_s1_reg, osp_sync;
  logic cvs_s1_reg, cvs_sync, cvs_prev_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic sw_mode_reg, seq_latched_reg;
  logic [2:0] idx_reg, idx_next, pending_reg;
  logic [2:0] osr_code_reg;
  logic [6:0] sample_cnt_reg;
  logic signed [ACC_W-1:0] acc_a_reg, acc_b_reg;
  ctl_state_t state_reg, state_next;
  logic [3:0] mux_a_reg, mux_b_reg;
  logic diag_reg;
  logic [1:0] filt_reg;
  logic res_valid_reg;
  logic [SAMPLE_W-1:0] res_a_reg, res_b_reg;
  logic [3:0] res_ch_a_reg, res_ch_b_reg;
  logic [SAMPLE_W-1:0] prev_a, prev_b;
  logic prev_a_ok, prev_b_ok;

  // Pins are asynchronous to clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {rng_s1_reg, rng_sync, seq_s1_reg, seq_sync, chsel_s1_reg, chsel_sync} <= '0;
      {osp_s1_reg, osp_sync, cvs_s1_reg, cvs_sync, cvs_prev_reg} <= '0;
    end else begin
      {rng_sync, rng_s1_reg} <= {rng_s1_reg, range_select_pins};
      {seq_sync, seq_s1_reg} <= {seq_s1_reg, sequencer_enable_pin};
      {chsel_sync, chsel_s1_reg} <= {chsel_s1_reg, channel_pair_select_pins};
      {osp_sync, osp_s1_reg} <= {osp_s1_reg, oversample_ratio_pins};
      {cvs_prev_reg, cvs_sync, cvs_s1_reg} <= {cvs_sync, cvs_s1_reg, conversion_start_pin};
    end
  end

  wire conversion_start_pin_rise = cvs_sync & ~cvs_prev_reg;
  // Straps are caught once the synchronisers hold real pin levels
  wire strap_capture = !strap_done_reg && (strap_cnt_reg == STRAP_WAIT);
  wire seq_on = sw_mode_reg ? sw_seq_enable : seq_latched_reg; // RULE7
  wire [2:0] osr_code_in = sw_mode_reg ? oversample_ratio_bits : osp_sync; // RULE8
  wire [6:0] osr_last = osr_last_f(osr_code_reg); // RULE9
  wire bypass = (osr_code_reg == OSR_OFF);
  wire set_done = (state_reg == ST_WAIT) && adc_done && (sample_cnt_reg == osr_last);
  wire burst_more = seq_on && burst_enable && (idx_reg != seq_last_index);

  // Software selections above the diagnostic index fold onto it
  wire [3:0] sw_a = (sw_chan_a_sel > MUX_DIAG_IDX) ? MUX_DIAG_IDX : sw_chan_a_sel;
  wire [3:0] sw_b = (sw_chan_b_sel > MUX_DIAG_IDX) ? MUX_DIAG_IDX : sw_chan_b_sel;
  // Mux follows the next slot so a set's first strobe already sees its own channel
  wire [3:0] sel_a = (sw_mode_reg && !seq_on) ? sw_a : {1'b0, idx_next}; // RULE6 RULE16 RULE5
  wire [3:0] sel_b = (sw_mode_reg && !seq_on) ? sw_b : {1'b0, idx_next}; // RULE6 RULE16 RULE5
  wire filt_sw = sw_mode_reg && (sw_filter_setting inside {FILT_SET_TWO, FILT_SET_THREE});
  wire [1:0] filt_sel = filt_sw ? sw_filter_setting : FILT_SET_ONE; // RULE1

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      sw_mode_reg <= 1'b1;
      seq_latched_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_capture) begin
        strap_done_reg <= 1'b1;
        sw_mode_reg <= (rng_sync == RANGE_SW_CODE); // RULE15
        seq_latched_reg <= seq_sync; // RULE17
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = (conversion_start_pin_rise && strap_done_reg) ? ST_SAMPLE : ST_IDLE; // RULE10
      ST_SAMPLE: state_next = ST_WAIT;
      ST_WAIT: begin
        if (set_done) begin
          state_next = ST_FINISH; // RULE12
        end else if (adc_done) begin
          state_next = ST_SAMPLE; // RULE10
        end
      end
      ST_FINISH: state_next = burst_more ? ST_SAMPLE : ST_IDLE; // RULE7 RULE12
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    idx_next = idx_reg;
    if (strap_capture) begin
      idx_next = chsel_sync; // RULE3
    end else if (state_reg == ST_FINISH) begin
      if (seq_on) begin
        idx_next = (idx_reg == seq_last_index) ? 3'h0 : idx_reg + 3'h1;
      end else if (!sw_mode_reg) begin
        idx_next = pending_reg; // RULE4
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      idx_reg <= 3'h0;
      pending_reg <= 3'h0;
      osr_code_reg <= OSR_OFF;
      sample_cnt_reg <= 7'h0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      if (state_reg == ST_WAIT && adc_done) begin
        pending_reg <= chsel_sync; // RULE4
      end
      // Ratio frozen for a whole burst so a mid-set change cannot skew it
      if (state_reg == ST_IDLE) begin
        osr_code_reg <= osr_code_in; // RULE8
      end
      if (state_reg == ST_FINISH || state_reg == ST_IDLE) begin
        sample_cnt_reg <= 7'h0;
      end else if (state_reg == ST_WAIT && adc_done) begin
        sample_cnt_reg <= sample_cnt_reg + 7'h1;
      end
    end
  end

  // First stage: boxcar sum of the channel's set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_a_reg <= '0;
      acc_b_reg <= '0;
    end else if (state_reg == ST_IDLE || state_reg == ST_FINISH) begin
      acc_a_reg <= '0;
      acc_b_reg <= '0;
    end else if (state_reg == ST_WAIT && adc_done) begin
      acc_a_reg <= acc_a_reg + ACC_W'(signed'(adc_data_a)); // RULE11
      acc_b_reg <= acc_b_reg + ACC_W'(signed'(adc_data_b)); // RULE11
    end
  end

  wire signed [ACC_W-1:0] mean_a_w = acc_a_reg >>> osr_code_reg;
  wire signed [ACC_W-1:0] mean_b_w = acc_b_reg >>> osr_code_reg;
  wire [SAMPLE_W-1:0] mean_a = mean_a_w[SAMPLE_W-1:0];
  wire [SAMPLE_W-1:0] mean_b = mean_b_w[SAMPLE_W-1:0];
  // Second stage: a second boxcar over consecutive means gives the sinc2 shape
  wire [SAMPLE_W:0] sum_a = {mean_a[SAMPLE_W-1], mean_a} +
                            {prev_a[SAMPLE_W-1], prev_a};
  wire [SAMPLE_W:0] sum_b = {mean_b[SAMPLE_W-1], mean_b} +
                            {prev_b[SAMPLE_W-1], prev_b};
  wire [SAMPLE_W-1:0] out_a = bypass ? acc_a_reg[SAMPLE_W-1:0] :
                              prev_a_ok ? sum_a[SAMPLE_W:1] : mean_a; // RULE14
  wire [SAMPLE_W-1:0] out_b = bypass ? acc_b_reg[SAMPLE_W-1:0] :
                              prev_b_ok ? sum_b[SAMPLE_W:1] : mean_b; // RULE14
  wire hist_wr = (state_reg == ST_FINISH) && !bypass;
  prev_mean_mem mem_a (
    .clk(clk), .resetn(resetn),
    .wr_en(hist_wr), .wr_addr(mux_a_reg), .wr_data(mean_a),
    .rd_addr(mux_a_reg), .rd_data(prev_a), .rd_valid(prev_a_ok)
  );

  prev_mean_mem mem_b (
    .clk(clk), .resetn(resetn),
    .wr_en(hist_wr), .wr_addr(mux_b_reg), .wr_data(mean_b),
    .rd_addr(mux_b_reg), .rd_data(prev_b), .rd_valid(prev_b_ok)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mux_a_reg <= 4'h0;
      mux_b_reg <= 4'h0;
      diag_reg <= 1'b0;
      filt_reg <= FILT_SET_ONE;
      res_valid_reg <= 1'b0;
      res_a_reg <= '0;
      res_b_reg <= '0;
      res_ch_a_reg <= 4'h0;
      res_ch_b_reg <= 4'h0;
    end else begin
      mux_a_reg <= sel_a; // RULE2
      mux_b_reg <= sel_b; // RULE2
      diag_reg <= sw_mode_reg & sw_diag_sel; // RULE5
      filt_reg <= filt_sel; // RULE1
      // One result per finished set, so the rate falls with the ratio
      res_valid_reg <= (state_reg == ST_FINISH); // RULE13
      if (state_reg == ST_FINISH) begin
        res_a_reg <= out_a; // RULE11
        res_b_reg <= out_b; // RULE11
        res_ch_a_reg <= mux_a_reg;
        res_ch_b_reg <= mux_b_reg;
      end
    end
  end

  assign sample_strobe = (state_reg == ST_SAMPLE);
  assign busy = (state_reg != ST_IDLE);
  assign mux_a_sel = mux_a_reg;
  assign mux_b_sel = mux_b_reg;
  assign diag_sel = diag_reg;
  assign filter_corner_sel = filt_reg;
  assign software_mode = sw_mode_reg;
  assign result_valid = res_valid_reg;
  assign result_a = res_a_reg;
  assign result_b = res_b_reg;
  assign result_chan_a = res_ch_a_reg;
  assign result_chan_b = res_ch_b_reg;

  a_filter_decode: assert property (@(posedge clk) disable iff (!resetn) // RULE1
    (sw_mode_reg && sw_filter_setting == FILT_SET_THREE) |=> filter_corner_sel == FILT_SET_THREE)
    else $error("filter corner not decoded");
  a_hw_no_diag: assert property (@(posedge clk) disable iff (!resetn) // RULE5
    (!sw_mode_reg && $past(!sw_mode_reg)) |-> (mux_a_sel < MUX_DIAG_IDX && !diag_sel))
    else $error("diagnostic input selected in hardware mode");
  a_hw_pair_match: assert property (@(posedge clk) disable iff (!resetn) // RULE16
    (!sw_mode_reg && $past(!sw_mode_reg)) |-> mux_a_sel == mux_b_sel)
    else $error("hardware pair indices differ");
  a_first_on_edge: assert property (@(posedge clk) disable iff (!resetn) // RULE10
    (state_reg == ST_IDLE && conversion_start_pin_rise && strap_done_reg) |=> sample_strobe ##1 !sample_strobe)
    else $error("first sample not on start edge");
  a_set_length: assert property (@(posedge clk) disable iff (!resetn) // RULE12
    set_done |=> (state_reg == ST_FINISH) ##1 result_valid)
    else $error("set not closed after full count");
  a_bypass_pass: assert property (@(posedge clk) disable iff (!resetn) // RULE14
    (state_reg == ST_FINISH && bypass) |=> result_a == $past(acc_a_reg[SAMPLE_W-1:0]))
    else $error("bypass result differs from sample");
  a_strap_pair: assert property (@(posedge clk) disable iff (!resetn) // RULE3
    strap_capture |=> idx_reg == $past(chsel_sync))
    else $error("initial pair not taken from pins");
  a_mode_strap: assert property (@(posedge clk) disable iff (!resetn) // RULE15
    strap_capture |=> sw_mode_reg == ($past(rng_sync) == RANGE_SW_CODE))
    else $error("mode strap wrong");
  a_seq_strap: assert property (@(posedge clk) disable iff (!resetn) // RULE17
    strap_capture |=> seq_latched_reg == $past(seq_sync))
    else $error("sequencer strap wrong");
  a_hw_resample: assert property (@(posedge clk) disable iff (!resetn) // RULE4
    (state_reg == ST_FINISH && !sw_mode_reg && !seq_on) |=> idx_reg == $past(pending_reg))
    else $error("hardware pair not resampled");
endmodule

//--- tb/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Converter handshake
  input wire logic sample_strobe,
  input wire logic [1:0] lat,
  output logic adc_done,
  output logic [15:0] adc_data_a,
  output logic [15:0] adc_data_b
);
  logic [2:0] wait_cnt;
  logic [15:0] k;
  wire logic [15:0] val_a = 16'h0100 + k;
  wire logic [15:0] val_b = 16'hff00 - k;
  // Outside the done pulse the data lines flip so a stale value is never mistaken for data
  assign adc_data_a = adc_done ? val_a : ~val_a;
  assign adc_data_b = adc_done ? val_b : ~val_b;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 3'h0;
      adc_done <= 1'b0;
      k <= 16'h0;
    end else begin
      adc_done <= (wait_cnt == 3'h1);
      if (sample_strobe) wait_cnt <= {1'b0, lat} + 3'h1;
      else if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
      if (adc_done) k <= k + 16'h1;
    end
  end
endmodule

//--- tb/tb_adc_mux_oversample_control.sv
`timescale 1ns/1ps
module tb_adc_mux_oversample_control;
  import adc_ctl_pkg::*;
  logic clk, resetn, sequencer_enable_pin, conversion_start_pin, sw_diag_sel, sw_seq_enable;
  logic burst_enable, sample_strobe, adc_done, diag_sel, software_mode, busy, result_valid;
  logic [1:0] range_select_pins, sw_filter_setting, filter_corner_sel, lat;
  logic [2:0] channel_pair_select_pins, oversample_ratio_pins, oversample_ratio_bits;
  logic [2:0] seq_last_index;
  logic [3:0] sw_chan_a_sel, sw_chan_b_sel, mux_a_sel, mux_b_sel, result_chan_a, result_chan_b;
  logic [SAMPLE_W-1:0] adc_data_a, adc_data_b, result_a, result_b;
  int n_errors = 0, n_compared = 0, n_strobes = 0, cycles = 0, seed = 3;
  logic [3:0] ra, rb;
  logic [15:0] n;

  adc_mux_oversample_control u_adc_mux_oversample_control (.clk(clk), .resetn(resetn),
    .range_select_pins(range_select_pins), .sequencer_enable_pin(sequencer_enable_pin),
    .channel_pair_select_pins(channel_pair_select_pins),
    .oversample_ratio_pins(oversample_ratio_pins), .conversion_start_pin(conversion_start_pin),
    .sw_chan_a_sel(sw_chan_a_sel), .sw_chan_b_sel(sw_chan_b_sel), .sw_diag_sel(sw_diag_sel),
    .oversample_ratio_bits(oversample_ratio_bits), .sw_filter_setting(sw_filter_setting),
    .sw_seq_enable(sw_seq_enable), .burst_enable(burst_enable),
    .seq_last_index(seq_last_index), .sample_strobe(sample_strobe), .adc_done(adc_done),
    .adc_data_a(adc_data_a), .adc_data_b(adc_data_b), .mux_a_sel(mux_a_sel),
    .mux_b_sel(mux_b_sel), .diag_sel(diag_sel), .filter_corner_sel(filter_corner_sel),
    .software_mode(software_mode), .busy(busy), .result_valid(result_valid),
    .result_a(result_a), .result_b(result_b), .result_chan_a(result_chan_a),
    .result_chan_b(result_chan_b));
  adc_core_model u_adc_core_model (.clk(clk), .resetn(resetn), .sample_strobe(sample_strobe),
    .lat(lat), .adc_done(adc_done), .adc_data_a(adc_data_a), .adc_data_b(adc_data_b));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (sample_strobe === 1'b1) n_strobes++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Straps must be steady from release until they are captured
  task automatic do_reset(input logic [1:0] rng, input logic seq, input logic [2:0] ch);
    @(posedge clk);
    resetn <= 1'b0;
    range_select_pins <= rng;
    sequencer_enable_pin <= seq;
    channel_pair_select_pins <= ch;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic start_conv();
    @(posedge clk);
    #1 n_strobes = 0;
    lat = 2'($unsigned($random(seed)));
    @(posedge clk);
    conversion_start_pin <= 1'b1;
    repeat (2) @(posedge clk);
    conversion_start_pin <= 1'b0;
  endtask
  task automatic wait_result();
    do begin
      @(posedge clk);
      #1;
    end while (result_valid !== 1'b1);
  endtask

  initial begin
    resetn = 1'b0;
    range_select_pins = 2'h0;
    sequencer_enable_pin = 1'b0;
    channel_pair_select_pins = 3'h0;
    oversample_ratio_pins = 3'h0;
    conversion_start_pin = 1'b0;
    sw_chan_a_sel = 4'h0;
    sw_chan_b_sel = 4'h0;
    sw_diag_sel = 1'b0;
    oversample_ratio_bits = 3'h0;
    sw_filter_setting = 2'h0;
    sw_seq_enable = 1'b0;
    burst_enable = 1'b0;
    seq_last_index = 3'h0;
    lat = 2'h1;
    do_reset(2'h0, 1'b0, 3'h0);
    check("software_mode", 16'(software_mode), 16'h1);
    for (int f = 0; f < 4; f++) begin
      sw_filter_setting <= 2'(f);
      repeat (3) @(posedge clk);
      #1 check("filter", 16'(filter_corner_sel), (f == 3) ? 16'h0 : 16'(f));
    end
    ra = 4'($unsigned($random(seed)) % 9);
    rb = 4'($unsigned($random(seed)) % 9);
    sw_chan_a_sel <= ra;
    sw_chan_b_sel <= 4'h8;
    sw_diag_sel <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("mux_a", 16'(mux_a_sel), 16'(ra));
    check("mux_b diag", 16'(mux_b_sel), 16'(MUX_DIAG_IDX));
    check("diag_sel", 16'(diag_sel), 16'h1);
    sw_chan_b_sel <= rb;
    repeat (3) @(posedge clk);
    #1 check("mux_b", 16'(mux_b_sel), 16'(rb));
    for (int c = 0; c < 8; c++) begin
      do_reset(2'h0, 1'b0, 3'h0);
      oversample_ratio_bits <= 3'(c);
      oversample_ratio_pins <= 3'(7 - c);
      start_conv();
      wait_result();
      n = 16'h1 << c;
      check("strobes", 16'(n_strobes), n);
      check("result_a", result_a, 16'h0100 + ((n - 16'h1) >> 1));
      check("result_b", result_b, 16'hff00 - (n >> 1));
      check("busy", 16'(busy), 16'h0);
    end
    // Two sets on one pair: the second result blends both set means
    do_reset(2'h0, 1'b0, 3'h0);
    oversample_ratio_bits <= 3'h1;
    repeat (2) begin
      start_conv();
      wait_result();
    end
    check("sinc2 a", result_a, 16'h0101);
    check("sinc2 b", result_b, 16'hfefe);
    sw_chan_b_sel <= 4'h8;
    sw_filter_setting <= 2'h2;
    do_reset(2'h1, 1'b0, 3'h3);
    check("hw mode", 16'(software_mode), 16'h0);
    check("hw mux_a", 16'(mux_a_sel), 16'h3);
    check("hw mux_b", 16'(mux_b_sel), 16'h3);
    check("hw diag", 16'(diag_sel), 16'h0);
    check("hw filter", 16'(filter_corner_sel), 16'(FILT_SET_ONE));
    oversample_ratio_pins <= 3'h2;
    oversample_ratio_bits <= 3'h0;
    start_conv();
    ra = 4'($unsigned($random(seed)) % 8);
    channel_pair_select_pins <= 3'(ra);
    repeat (2) @(posedge clk);
    #1 check("busy", 16'(busy), 16'h1);
    wait_result();
    check("hw strobes", 16'(n_strobes), 16'h4);
    check("hw result chan", 16'(result_chan_a), 16'h3);
    repeat (2) @(posedge clk);
    #1 check("next pair", 16'(mux_a_sel), 16'(ra));
    do_reset(2'h3, 1'b1, 3'h0);
    burst_enable <= 1'b1;
    seq_last_index <= 3'h2;
    oversample_ratio_pins <= 3'h1;
    start_conv();
    for (int i = 0; i < 3; i++) begin
      wait_result();
      check("seq chan a", 16'(result_chan_a), 16'(i));
      check("seq chan b", 16'(result_chan_b), 16'(i));
      check("seq strobes", 16'(n_strobes), 16'(2 * i + 2));
    end
    // Sequencer burst in software mode, ratio off
    do_reset(2'h0, 1'b0, 3'h0);
    sw_seq_enable <= 1'b1;
    seq_last_index <= 3'h1;
    oversample_ratio_bits <= 3'h0;
    start_conv();
    for (int i = 0; i < 2; i++) begin
      wait_result();
      check("sw seq chan", 16'(result_chan_b), 16'(i));
      check("sw seq strobes", 16'(n_strobes), 16'(i + 1));
      check("sw seq raw", result_a, 16'h0100 + 16'(i));
    end
    report_and_stop();
  end
endmodule
